// ===== lcd_map.svh
// register offsets, field positions and timing counts of the lcd driver
`ifndef LCD_MAP_SVH
`define LCD_MAP_SVH

`define ADDR_CTRL 7'h31
`define ADDR_MODE 7'h32
`define ADDR_STAT 7'h33
`define ADDR_PAT_FIRST 7'h40
`define ADDR_PAT_LAST 7'h63

`define CTRL_ON_BIT 3
`define CTRL_RATE_MSB 2
`define STAT_PHASE_BIT 3
`define MODE_SEL_MSB 1
`define MODE_HALF 2'h0
`define MODE_THIRD 2'h1

`define SEG_PINS 36
`define PIN_COM2 35
`define PIN_COM3 34
`define SLOT_COM2 2'h2
`define SLOT_COM3 2'h3

`define LVL_0 2'h0
`define LVL_1 2'h1
`define LVL_2 2'h2
`define LVL_3 2'h3

`define CLK_PERIOD_NS 100
`define HALF_SLOT_NS 32000
`define HALF_SLOT_CYCLES (`HALF_SLOT_NS / `CLK_PERIOD_NS)
`define TIMER_W 24

`endif

// ===== lcd_pkg.sv
// types shared by the lcd driver modules
package lcd_pkg;

   typedef enum logic [1:0] {DUTY_HALF, DUTY_THIRD, DUTY_QUARTER} duty_t;

   typedef logic [1:0] level_t;

endpackage

// ===== lcd_slot_timer.sv
// half-slot tick divider, period scaled by the frame rate field
`timescale 1ns/10ps
`include "lcd_map.svh"

module lcd_slot_timer
   import lcd_pkg::*;
#(
   parameter int HALF_SLOT_CYCLES = `HALF_SLOT_CYCLES
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [2:0] rate_sel,
   output logic tick
);

   logic [`TIMER_W-1:0] count_ff;
   logic [2:0] rate_seen_ff;
   logic [`TIMER_W-1:0] limit;

   assign limit = (`TIMER_W'(HALF_SLOT_CYCLES) << rate_sel) - `TIMER_W'(1);

   // restart on a rate change so the first period at the new rate runs its full limit
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         count_ff <= '0;
         rate_seen_ff <= 3'h0;
         tick <= 1'b0;
      end
      else if (rate_sel != rate_seen_ff)
      begin
         count_ff <= '0;
         rate_seen_ff <= rate_sel;
         tick <= 1'b0;
      end
      else if (count_ff >= limit)
      begin
         count_ff <= '0;
         tick <= 1'b1;
      end
      else
      begin
         count_ff <= count_ff + `TIMER_W'(1);
         tick <= 1'b0;
      end
   end

endmodule

// ===== lcd_segment_common_driver.sv
// multiplexed lcd segment and common driver with register port
// How it works
// RULE_01 - four commons, thirty-four segments, two shared pins
// RULE_02 - shared pins follow common pin mode field
// RULE_03 - mode gives 72, 105 or 136 dots
// RULE_04 - waveforms use fixed one-third bias levels
// RULE_05 - duty half, third or quarter by commons
// RULE_06 - frame rate field sets frame frequency
// RULE_07 - pattern taken from registers 40H to 63H
// RULE_08 - lit dot gets full select potential
// RULE_09 - display_on bit switches display on or off
// RULE_10 - display off drives all segments dark
// RULE_11 - any reset source clears display_on
// RULE_12 - register per segment, bit n is common n
//
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
`include "lcd_map.svh"

module lcd_segment_common_driver
   import lcd_pkg::*;
#(
   parameter int HALF_SLOT_CYCLES = `HALF_SLOT_CYCLES
)
(
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic [6:0] ADDR,
   input wire logic [3:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic LOWV_DET,
   input wire logic WDOG_RST,
   output logic [3:0] RDATA,
   output logic [71:0] SEGMENT_OUT,
   output logic [3:0] COMMON_OUT
);

   logic display_on_ff;
   logic [2:0] frame_rate_ff;
   logic [3:0] pin_mode_ff;
   logic [3:0] pattern_ff [0:`SEG_PINS-1];
   logic [1:0] slot_ff;
   logic phase_ff;
   logic tick;
   duty_t duty;
   logic [2:0] ncom;
   logic [1:0] nxt_slot;
   logic nxt_phase;
   logic [71:0] nxt_seg;
   logic [3:0] nxt_com;
   logic [6:0] pat_offset;
   logic [5:0] pat_index;

   function automatic duty_t duty_of(input logic [3:0] mode);
      duty_t d;
      if (mode[`MODE_SEL_MSB:0] == `MODE_HALF)
         d = DUTY_HALF;
      else if (mode[`MODE_SEL_MSB:0] == `MODE_THIRD)
         d = DUTY_THIRD;
      else
         d = DUTY_QUARTER;
      return d;
   endfunction

   function automatic logic [2:0] com_count(input duty_t d);
      logic [2:0] n;
      unique case (d)
         DUTY_HALF: n = 3'h2;
         DUTY_THIRD: n = 3'h3;
         DUTY_QUARTER: n = 3'h4;
      endcase
      return n;
   endfunction

   // segment side: lit sits opposite the select level, unlit one third off
   function automatic level_t seg_level(input logic lit, input logic ph);
      level_t l;
      if (lit)
         l = ph ? `LVL_3 : `LVL_0;
      else
         l = ph ? `LVL_1 : `LVL_2;
      return l;
   endfunction

   function automatic level_t com_level(input logic sel, input logic ph);
      level_t l;
      if (sel)
         l = ph ? `LVL_0 : `LVL_3;
      else
         l = ph ? `LVL_2 : `LVL_1;
      return l;
   endfunction

   function automatic logic in_pattern(input logic [6:0] a);
      return (a >= `ADDR_PAT_FIRST) && (a <= `ADDR_PAT_LAST);
   endfunction

   lcd_slot_timer #(
      .HALF_SLOT_CYCLES(HALF_SLOT_CYCLES)
   ) u_timer (
      .clk(CORE_CLK),
      .rst_n(RST_N),
      .rate_sel(frame_rate_ff), // [RULE_06]
      .tick(tick)
   );

   assign duty = duty_of(pin_mode_ff); // [RULE_02] [RULE_03]
   assign ncom = com_count(duty); // [RULE_05]
   assign pat_offset = ADDR - `ADDR_PAT_FIRST;
   assign pat_index = pat_offset[5:0];

   // display enable: every reset source forces blanking
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N || LOWV_DET || WDOG_RST) // [RULE_11]
         display_on_ff <= 1'b0;
      else if (WR && ADDR == `ADDR_CTRL)
         display_on_ff <= WDATA[`CTRL_ON_BIT]; // [RULE_09]
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
         frame_rate_ff <= 3'h0;
      else if (WR && ADDR == `ADDR_CTRL)
         frame_rate_ff <= WDATA[`CTRL_RATE_MSB:0]; // [RULE_06]
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
         pin_mode_ff <= 4'h0;
      else if (WR && ADDR == `ADDR_MODE)
         pin_mode_ff <= WDATA; // [RULE_02]
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         for (int i = 0; i < `SEG_PINS; i++)
            pattern_ff[i] <= 4'h0;
      end
      else if (WR && in_pattern(ADDR))
         pattern_ff[pat_index] <= WDATA; // [RULE_07]
   end

   // read data stands in the cycle after the strobe only
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N || !RD)
         RDATA <= 4'h0;
      else if (ADDR == `ADDR_CTRL)
         RDATA <= {display_on_ff, frame_rate_ff};
      else if (ADDR == `ADDR_MODE)
         RDATA <= pin_mode_ff;
      else if (ADDR == `ADDR_STAT)
         RDATA <= {phase_ff, 1'b0, slot_ff};
      else if (in_pattern(ADDR))
         RDATA <= pattern_ff[pat_index];
      else
         RDATA <= 4'h0;
   end

   // scan order: both phases of a slot, then the next active common
   always_comb
   begin
      nxt_phase = ~phase_ff;
      if ({1'b0, slot_ff} >= ncom)
         nxt_slot = 2'h0;
      else if (phase_ff && ({1'b0, slot_ff} == ncom - 3'h1)) // [RULE_05]
         nxt_slot = 2'h0;
      else if (phase_ff)
         nxt_slot = slot_ff + 2'h1;
      else
         nxt_slot = slot_ff;
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         slot_ff <= 2'h0;
         phase_ff <= 1'b0;
      end
      else if (tick)
      begin
         slot_ff <= nxt_slot;
         phase_ff <= nxt_phase;
      end
   end

   always_comb
   begin
      nxt_seg = '0;
      nxt_com = '0;
      for (int i = 0; i < `SEG_PINS; i++)
         nxt_seg[2*i +: 2] = seg_level(display_on_ff // [RULE_10]
            && pattern_ff[i][nxt_slot], nxt_phase); // [RULE_08] [RULE_12]
      if (duty != DUTY_HALF) // [RULE_01] [RULE_02]
         nxt_seg[2*`PIN_COM2 +: 2] =
            com_level(nxt_slot == `SLOT_COM2, nxt_phase);
      if (duty == DUTY_QUARTER) // [RULE_01] [RULE_02]
         nxt_seg[2*`PIN_COM3 +: 2] =
            com_level(nxt_slot == `SLOT_COM3, nxt_phase);
      nxt_com[1:0] = com_level(nxt_slot == 2'h0, nxt_phase); // [RULE_04]
      nxt_com[3:2] = com_level(nxt_slot == 2'h1, nxt_phase); // [RULE_04]
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         SEGMENT_OUT <= '0;
         COMMON_OUT <= '0;
      end
      else if (tick)
      begin
         SEGMENT_OUT <= nxt_seg;
         COMMON_OUT <= nxt_com;
      end
   end

   // tick spacing watch, restarted when the rate changes
   logic [`TIMER_W-1:0] gap_ff;
   logic gap_valid_ff;
   logic [2:0] gap_rate_ff;
   logic [`TIMER_W-1:0] gap_expect;

   assign gap_expect = (`TIMER_W'(HALF_SLOT_CYCLES) << frame_rate_ff)
      - `TIMER_W'(1);

   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N || gap_rate_ff != frame_rate_ff)
      begin
         gap_ff <= '0;
         gap_valid_ff <= 1'b0;
         gap_rate_ff <= frame_rate_ff;
      end
      else if (tick)
      begin
         gap_ff <= '0;
         gap_valid_ff <= 1'b1;
      end
      else
         gap_ff <= gap_ff + `TIMER_W'(1);
   end

   chk_reset_blanks: assert property ( // [RULE_11]
      @(posedge CORE_CLK) (!RST_N || LOWV_DET || WDOG_RST)
         |=> !display_on_ff)
      else $error("display_on survived a reset source");

   chk_ctrl_readback: assert property ( // [RULE_09]
      @(posedge CORE_CLK) disable iff (!RST_N)
      (RD && ADDR == `ADDR_CTRL)
         |=> RDATA == $past({display_on_ff, frame_rate_ff}))
      else $error("control read back wrong");

   chk_blank_segments: assert property ( // [RULE_10]
      @(posedge CORE_CLK) disable iff (!RST_N)
      (tick && !display_on_ff)
         |=> SEGMENT_OUT[1:0] == (phase_ff ? `LVL_1 : `LVL_2))
      else $error("segment not dark while display off");

   chk_lit_dot: assert property ( // [RULE_08]
      @(posedge CORE_CLK) disable iff (!RST_N)
      (tick && display_on_ff && pattern_ff[0][nxt_slot])
         |=> SEGMENT_OUT[1:0] == (phase_ff ? `LVL_3 : `LVL_0))
      else $error("lit dot lacks full select level");

   chk_select_common: assert property ( // [RULE_04]
      @(posedge CORE_CLK) disable iff (!RST_N)
      (tick && nxt_slot == 2'h0)
         |=> COMMON_OUT[1:0] == (phase_ff ? `LVL_0 : `LVL_3)
            && COMMON_OUT[3:2] == (phase_ff ? `LVL_2 : `LVL_1))
      else $error("common levels not one-third bias");

   chk_slot_range: assert property ( // [RULE_05]
      @(posedge CORE_CLK) disable iff (!RST_N)
      $past(tick) && $past(RST_N) |-> {1'b0, slot_ff} < $past(ncom))
      else $error("scan slot beyond active commons");

   chk_shared_segment: assert property ( // [RULE_02]
      @(posedge CORE_CLK) disable iff (!RST_N)
      (tick && duty == DUTY_HALF && !display_on_ff)
         |=> SEGMENT_OUT[2*`PIN_COM2 +: 2] == (phase_ff ? `LVL_1 : `LVL_2))
      else $error("shared pin not acting as segment");

   chk_shared_common: assert property ( // [RULE_01]
      @(posedge CORE_CLK) disable iff (!RST_N)
      (tick && duty == DUTY_QUARTER && nxt_slot == `SLOT_COM3)
         |=> SEGMENT_OUT[2*`PIN_COM3 +: 2] == (phase_ff ? `LVL_0 : `LVL_3))
      else $error("shared pin not acting as common");

   chk_tick_spacing: assert property ( // [RULE_06]
      @(posedge CORE_CLK) disable iff (!RST_N)
      (tick && gap_valid_ff && gap_rate_ff == frame_rate_ff)
         |-> gap_ff == gap_expect)
      else $error("half slot period does not follow frame rate");

   chk_pattern_store: assert property ( // [RULE_07]
      @(posedge CORE_CLK) disable iff (!RST_N)
      (WR && ADDR == `ADDR_PAT_FIRST) ##1 (RD && ADDR == `ADDR_PAT_FIRST)
         |=> RDATA == $past(WDATA, 2))
      else $error("pattern register lost a write");

endmodule

// ===== lcd_glass_panel.sv
// passive glass model flagging dots that see full select potential
`timescale 1ns/10ps
module lcd_glass_panel
   import lcd_pkg::*;
(
   input wire logic [71:0] seg_lvl,
   input wire logic [3:0] com_lvl,
   output logic [143:0] lit
);
   function automatic logic [143:0] glow(input logic [71:0] s,
      input logic [3:0] k);
      level_t cl [4];
      int d;
      glow = '0;
      cl[0] = k[1:0];
      cl[1] = k[3:2];
      cl[2] = s[71:70];
      cl[3] = s[69:68];
      for (int i = 0; i < 36; i++)
         for (int c = 0; c < 4; c++)
         begin
            d = int'(s[i*2+:2]) - int'(cl[c]);
            glow[i*4+c] = (d == 3 || d == -3);
         end
   endfunction
   assign lit = glow(seg_lvl, com_lvl);
endmodule

// ===== test_lcd_segment_common_driver.sv
// self-checking bench of the lcd segment and common driver
`timescale 1ns/10ps
module test_lcd_segment_common_driver
   import lcd_pkg::*;
;
   localparam int HSC = 4;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic wr = 1'h0;
   logic rd = 1'h0;
   logic lowv = 1'h0;
   logic wdog = 1'h0;
   logic [6:0] addr = 7'h00;
   logic [3:0] wdata = 4'h0;
   logic [3:0] rdata;
   logic [3:0] com;
   logic [71:0] seg;
   logic [143:0] lit;
   int n_mismatch = 0;
   int checked = 0;
   int pat [36];
   int ncom;
   int nseg;
   int n;

   lcd_segment_common_driver #(.HALF_SLOT_CYCLES(HSC))
      i_lcd_segment_common_driver (.CORE_CLK(clk), .RST_N(rst_n),
      .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .LOWV_DET(lowv),
      .WDOG_RST(wdog), .RDATA(rdata), .SEGMENT_OUT(seg),
      .COMMON_OUT(com));
   lcd_glass_panel i_lcd_glass_panel (.seg_lvl(seg), .com_lvl(com),
      .lit(lit));

   task automatic chk(input string nm, input logic [143:0] got, exp);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic reg_wr(input logic [6:0] a, input logic [3:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
   endtask

   task automatic reg_rd(input logic [6:0] a, input logic [3:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      @(negedge clk);
      chk("rdata", rdata, e);
   endtask

   task automatic scan(input int cycles, input bit on);
      int last;
      int found;
      int es;
      int seen;
      logic [143:0] got;
      logic [143:0] e;
      last = -1;
      seen = 0;
      repeat (cycles)
      begin
         @(negedge clk);
         got = '0;
         for (int i = 0; i < nseg; i++)
            for (int c = 0; c < ncom; c++)
               got[i*4+c] = lit[i*4+c];
         if (!on)
            chk("dark", got, '0);
         else if (com !== 4'h0)
         begin
            found = -1;
            for (int s = 0; s < ncom; s++)
            begin
               e = '0;
               for (int i = 0; i < nseg; i++)
                  e[i*4+s] = pat[i][s];
               if (got === e)
                  found = s;
            end
            es = (found == last && last >= 0) ? last : (last + 1) % ncom;
            if (last < 0 && found >= 0)
               es = found;
            chk("slot", found, es);
            last = found;
            if (found >= 0)
               seen = seen | (1 << found);
         end
      end
      if (on)
         chk("duty", seen, (1 << ncom) - 1);
   endtask

   task automatic half(output int cnt);
      logic [3:0] prev;
      prev = com;
      cnt = 0;
      do
      begin
         @(negedge clk);
         cnt++;
      end
      while (com === prev && cnt < 3000);
   endtask

   task test_done;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial
   begin
      forever #50 clk = ~clk;
   end

   initial
   begin
      #5000000;
      n_mismatch++;
      test_done;
   end

   initial
   begin
      void'($urandom(32'h0DE7C9EA));
      repeat (6) @(posedge clk);
      rst_n <= 1'h1;
      reg_rd(7'h31, 4'h0);
      reg_rd(7'h32, 4'h0);
      reg_wr(7'h64, 4'hF);
      reg_rd(7'h64, 4'h0);
      @(negedge clk);
      chk("rdata idle", rdata, 4'h0);
      for (int i = 0; i < 36; i++)
      begin
         pat[i] = $urandom_range(15);
         reg_wr(7'h40 + 7'(i), 4'(pat[i]));
      end
      for (int i = 0; i < 36; i++)
         reg_rd(7'h40 + 7'(i), 4'(pat[i]));
      $display("registers done");
      for (int m = 0; m < 4; m++)
      begin
         ncom = (m == 0) ? 2 : (m == 1) ? 3 : 4;
         nseg = 38 - ncom;
         reg_wr(7'h32, 4'(m));
         reg_wr(7'h31, 4'h8);
         repeat (10) @(posedge clk);
         scan(80, 1'h1);
         reg_wr(7'h31, 4'h0);
         repeat (10) @(posedge clk);
         scan(40, 1'h0);
      end
      $display("modes done");
      for (int r = 0; r < 8; r++)
      begin
         reg_wr(7'h31, 4'h8 | 4'(r));
         @(negedge clk);
         half(n);
         half(n);
         chk("half slot", n, HSC << r);
      end
      $display("rates done");
      @(posedge clk);
      lowv <= 1'h1;
      @(posedge clk);
      lowv <= 1'h0;
      reg_rd(7'h31, 4'h7);
      reg_wr(7'h31, 4'hF);
      @(posedge clk);
      wdog <= 1'h1;
      @(posedge clk);
      wdog <= 1'h0;
      reg_rd(7'h31, 4'h7);
      @(posedge clk);
      rst_n <= 1'h0;
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      reg_rd(7'h33, 4'h0);
      reg_rd(7'h31, 4'h0);
      reg_rd(7'h40, 4'h0);
      // write then read the same pattern word with no gap
      pat[0] = $urandom_range(15);
      @(posedge clk);
      addr <= 7'h40;
      wdata <= 4'(pat[0]);
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      @(negedge clk);
      chk("back to back", rdata, 4'(pat[0]));
      $display("resets done");
      test_done;
   end
endmodule
